// ### pirqm_top.sv
// Decided for this implementation: register access over APB.
`timescale 1ns/10ps
module pirqm_top
  import pirqm_pkg::*;
(
  // clock and reset
  input  wire logic           sys_clk,
  input  wire logic           reset,
  // apb slave
  input  wire pirqm_apb_req_s apb_req,
  output logic [31:0]         prdata,
  output logic                pready,
  output logic                pslverr,
  // peripheral event pulses, same clock domain
  input  wire pirqm_events_s  events,
  // towards the core interrupt combining logic
  output logic [7:0]          periph_irq_req,
  output logic                irq
);

  pirqm_state_s st_q;
  pirqm_state_s st_d;

  logic       setup;
  logic       access;
  logic       hit_enable;
  logic       hit_flag;
  logic [7:0] ev;

  function automatic logic [31:0] pirqm_zext(input logic [7:0] v);
    pirqm_zext = {24'h000000, v};
  endfunction : pirqm_zext

  assign setup      = apb_req.psel && !apb_req.penable;
  assign access     = apb_req.psel && apb_req.penable;
  assign hit_enable = (apb_req.paddr == PIRQM_ENABLE_ADDR);
  assign hit_flag   = (apb_req.paddr == PIRQM_FLAG_ADDR);
  // the unused bit never latches, so bit 3 reads zero
  assign ev         = events & PIRQM_IMPL_MASK;

  // zero wait states; data was latched in the setup cycle
  assign pready  = 1'b1;
  assign pslverr = access && !hit_enable && !hit_flag;
  assign prdata  = st_q.prdata;

  always_comb begin
    st_d = st_q;
    // set beats a same-cycle write-one-to-clear, so no event is lost
    if (access && apb_req.pwrite && hit_flag) begin
      st_d.flags = st_q.flags & ~apb_req.pwdata[7:0];
    end
    st_d.flags = (st_d.flags | ev) & PIRQM_IMPL_MASK;
    if (access && apb_req.pwrite && hit_enable) begin
      st_d.enable = apb_req.pwdata[7:0] & PIRQM_IMPL_MASK;
    end
    if (setup && !apb_req.pwrite) begin
      if (hit_enable) begin
        st_d.prdata = pirqm_zext(st_q.enable);
      end else if (hit_flag) begin
        st_d.prdata = pirqm_zext(st_q.flags);
      end else begin
        st_d.prdata = 32'h00000000;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      st_q <= '{enable: PIRQM_RESET_VAL, flags: PIRQM_RESET_VAL, prdata: 32'h00000000};
    end else begin
      st_q <= st_d;
    end
  end

  // enables are pure gates; flags themselves are never altered by them
  assign periph_irq_req = st_q.flags & st_q.enable;
  assign irq            = |periph_irq_req;

  // checked only once reset has gone low: the first edge still sees the flops unset
  a_enable_reset: assert property (@(posedge sys_clk)
    $past(reset) && !reset |-> st_q.enable == PIRQM_RESET_VAL)
    else $error("enable register not cleared by reset");

  a_enable_write: assert property (@(posedge sys_clk) disable iff (reset)
    access && apb_req.pwrite && hit_enable
    |=> st_q.enable == ($past(apb_req.pwdata[7:0]) & PIRQM_IMPL_MASK))
    else $error("enable write not stored");

  a_enable_read: assert property (@(posedge sys_clk) disable iff (reset)
    setup && !apb_req.pwrite && hit_enable && !apb_req.penable
    ##1 access && $stable(apb_req.paddr) && !apb_req.pwrite
    |-> prdata == {24'h000000, $past(st_q.enable)})
    else $error("enable read data wrong");

  a_bit3_zero: assert property (@(posedge sys_clk) disable iff (reset)
    !st_q.enable[PIRQM_BIT_UNUSED] && !st_q.flags[PIRQM_BIT_UNUSED])
    else $error("bit 3 not zero");

  a_req_gated: assert property (@(posedge sys_clk) disable iff (reset)
    (periph_irq_req & ~st_q.enable) == 8'h00 && (irq == |(st_q.flags & st_q.enable)))
    else $error("request passed without its enable");

  a_cmp_gate: assert property (@(posedge sys_clk) disable iff (reset)
    events.comparator_change && st_d.enable[PIRQM_BIT_CMP]
    |=> periph_irq_req[PIRQM_BIT_CMP] && irq)
    else $error("comparator request not passed");

  a_tx_block: assert property (@(posedge sys_clk) disable iff (reset)
    !st_q.enable[PIRQM_BIT_TX] |-> !periph_irq_req[PIRQM_BIT_TX])
    else $error("transmit request passed while disabled");

  a_tx_pass: assert property (@(posedge sys_clk) disable iff (reset)
    st_q.enable[PIRQM_BIT_TX] && st_q.flags[PIRQM_BIT_TX] |-> periph_irq_req[PIRQM_BIT_TX])
    else $error("transmit request blocked while enabled");

  a_flag_set: assert property (@(posedge sys_clk) disable iff (reset)
    ev != 8'h00 |=> (st_q.flags & $past(ev)) == $past(ev))
    else $error("event did not set its flag");

  a_err_unmapped: assert property (@(posedge sys_clk) disable iff (reset)
    access |-> pslverr == !(hit_enable || hit_flag))
    else $error("unmapped access answer wrong");

  // error is an access-phase answer only; an idle bus must never show it
  a_err_idle: assert property (@(posedge sys_clk) disable iff (reset)
    !access |-> !pslverr)
    else $error("error shown outside access phase");

  // zero wait states: the master never stalls on this block
  a_ready_high: assert property (@(posedge sys_clk) disable iff (reset)
    pready)
    else $error("ready dropped");

  // a write-one-to-clear removes only the bits written, events of that cycle survive
  a_flag_clear: assert property (@(posedge sys_clk) disable iff (reset)
    access && apb_req.pwrite && hit_flag
    |=> st_q.flags == ((($past(st_q.flags) & ~$past(apb_req.pwdata[7:0]))
                        | $past(ev)) & PIRQM_IMPL_MASK))
    else $error("flag clear wrong");

  // without a clear a flag never drops, whatever the enables do
  a_flag_hold: assert property (@(posedge sys_clk) disable iff (reset)
    !(access && apb_req.pwrite && hit_flag)
    |=> ($past(st_q.flags) & ~st_q.flags) == 8'h00)
    else $error("flag lost without a clear");

  // enables change only through their own register write
  a_enable_hold: assert property (@(posedge sys_clk) disable iff (reset)
    !(access && apb_req.pwrite && hit_enable) |=> $stable(st_q.enable))
    else $error("enable changed without a write");

  // read data is taken at the setup edge and must stand through the access phase
  a_prdata_hold: assert property (@(posedge sys_clk) disable iff (reset)
    !(setup && !apb_req.pwrite) |=> $stable(prdata))
    else $error("read data moved without a read");

  a_prdata_upper: assert property (@(posedge sys_clk) disable iff (reset)
    prdata[31:8] == 24'h000000)
    else $error("upper read data not zero");

  a_read_unmapped: assert property (@(posedge sys_clk) disable iff (reset)
    setup && !apb_req.pwrite && !hit_enable && !hit_flag |=> prdata == 32'h00000000)
    else $error("unmapped read not zero");

  // reset clears everything software can see, one edge later
  a_reset_clear: assert property (@(posedge sys_clk)
    reset |=> st_q.enable == PIRQM_RESET_VAL && st_q.flags == PIRQM_RESET_VAL && !irq)
    else $error("reset did not clear state");

endmodule : pirqm_top

// ### pirqm_pkg.sv
// Summary of operation
// - the enable register is one 8-bit read/write register at byte address 8Ch.
// - an implemented enable bit only gates its source request onto the interrupt logic.
// - bit 6 passes the comparator change request when set, blocks it when clear.
// - bit 4 passes the serial transmit-empty request when 1, blocks it when 0.
// - each flag is set by its event, whatever the enable bits hold.
package pirqm_pkg;

  localparam int          PIRQM_ADDR_W      = 12;
  localparam int          PIRQM_DATA_W      = 32;
  localparam int          PIRQM_REG_W       = 8;

  localparam logic [11:0] PIRQM_ENABLE_ADDR = 12'h08C;
  localparam logic [11:0] PIRQM_FLAG_ADDR   = 12'h00C;

  localparam logic [7:0]  PIRQM_IMPL_MASK   = 8'hF7;
  localparam logic [7:0]  PIRQM_RESET_VAL   = 8'h00;

  localparam int          PIRQM_BIT_EEPROM  = 7;
  localparam int          PIRQM_BIT_CMP     = 6;
  localparam int          PIRQM_BIT_RX      = 5;
  localparam int          PIRQM_BIT_TX      = 4;
  localparam int          PIRQM_BIT_UNUSED  = 3;
  localparam int          PIRQM_BIT_CCP     = 2;
  localparam int          PIRQM_BIT_TMR2    = 1;
  localparam int          PIRQM_BIT_TMR1    = 0;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } pirqm_apb_req_s;

  typedef struct packed {
    logic eeprom_write_done;
    logic comparator_change;
    logic serial_receive;
    logic serial_transmit;
    logic unused3;
    logic capture_compare;
    logic timer2_period_match;
    logic timer1_overflow;
  } pirqm_events_s;

  typedef struct packed {
    logic [7:0]  enable;
    logic [7:0]  flags;
    logic [31:0] prdata;
  } pirqm_state_s;

endpackage : pirqm_pkg

// ### pirqm_top_dummy_guard.sv
`timescale 1ns/10ps

// ### pirqm_periph_model.sv
`timescale 1ns/10ps
module pirqm_periph_model
  import pirqm_pkg::*;
(
  // clock
  input  wire logic       sys_clk,
  // bench asks a source to fire
  input  wire logic [7:0] fire,
  // event pulses
  output pirqm_events_s   events
);
  // one pulse a fired cycle, bit 3 has no source
  always_ff @(posedge sys_clk) begin
    events <= pirqm_events_s'(fire & PIRQM_IMPL_MASK);
  end
endmodule : pirqm_periph_model

// ### peripheral_irq_enable_mask_tb.sv
`timescale 1ns/10ps
module peripheral_irq_enable_mask_tb;
  import pirqm_pkg::*;
  logic           sys_clk = 0;
  logic           reset = 1;
  pirqm_apb_req_s apb_req = '0;
  logic [7:0]     fire = '0;
  pirqm_events_s  events;
  logic [31:0]    prdata, rd;
  logic           pready, pslverr, irq, err;
  logic [7:0]     req_out, m;
  int             num_errors = 0;
  int             n_checks = 0;
  always #4 sys_clk = ~sys_clk;
  pirqm_top dut (.sys_clk(sys_clk), .reset(reset), .apb_req(apb_req), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .events(events), .periph_irq_req(req_out), .irq(irq));
  pirqm_periph_model peri (.sys_clk(sys_clk), .fire(fire), .events(events));
  task chk(string what, logic [31:0] e, logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      num_errors++;
      $display("unexpected %s exp %h got %h", what, e, g);
    end
  endtask : chk
  // one full apb transfer; data and error taken at the pready edge
  task apb(logic wr, logic [11:0] a, logic [31:0] d);
    @(posedge sys_clk);
    apb_req <= '{1'b1, 1'b0, wr, a, d};
    @(posedge sys_clk);
    apb_req.penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    apb_req <= '0;
  endtask : apb
  task t_regs;
    apb(0, PIRQM_ENABLE_ADDR, 0); chk("reset", 32'h0, rd);
    apb(1, PIRQM_ENABLE_ADDR, 32'hFF);
    apb(0, PIRQM_ENABLE_ADDR, 0); chk("enable", 32'hF7, rd);
    apb(1, PIRQM_ENABLE_ADDR, 32'h00);
    apb(0, PIRQM_ENABLE_ADDR, 0); chk("cleared", 32'h0, rd);
    apb(0, 12'h090, 0); chk("slverr", 32'h1, {31'h0, err});
  endtask : t_regs
  // every source: flag without enable, gate opens on enable, clears on w1c
  task t_sources;
    for (int i = 0; i < 8; i++) begin
      if (i == PIRQM_BIT_UNUSED) continue;
      m = 8'h01 << i;
      apb(1, PIRQM_ENABLE_ADDR, 0);
      @(posedge sys_clk); fire <= m;
      @(posedge sys_clk); fire <= '0;
      repeat (2) @(posedge sys_clk);
      @(negedge sys_clk);
      chk("masked req", 32'h0, {23'h0, irq, req_out});
      apb(0, PIRQM_FLAG_ADDR, 0); chk("flag", {24'h0, m}, rd);
      apb(1, PIRQM_ENABLE_ADDR, {24'h0, m});
      @(negedge sys_clk); chk("enabled req", {23'h0, 1'b1, m}, {23'h0, irq, req_out});
      apb(1, PIRQM_FLAG_ADDR, {24'h0, m});
      @(negedge sys_clk); chk("cleared irq", 32'h0, {31'h0, irq});
    end
  endtask : t_sources
  // mid-run reset drops enables and flags; a flag cleared before enabling stays quiet
  task t_reset;
    apb(1, PIRQM_ENABLE_ADDR, 32'hFF);
    @(posedge sys_clk); fire <= 8'h01;
    @(posedge sys_clk); fire <= '0;
    repeat (2) @(posedge sys_clk);
    @(negedge sys_clk); chk("irq before reset", 32'h1, {31'h0, irq});
    @(posedge sys_clk); reset <= 1'b1;
    repeat (3) @(posedge sys_clk);
    reset <= 1'b0;
    @(negedge sys_clk); chk("irq after reset", 32'h0, {31'h0, irq});
    apb(0, PIRQM_ENABLE_ADDR, 0); chk("enable after reset", 32'h0, rd);
    apb(0, PIRQM_FLAG_ADDR, 0); chk("flag after reset", 32'h0, rd);
    @(posedge sys_clk); fire <= 8'h40;
    @(posedge sys_clk); fire <= '0;
    repeat (2) @(posedge sys_clk);
    apb(1, PIRQM_FLAG_ADDR, 32'h40);
    apb(1, PIRQM_ENABLE_ADDR, 32'h40);
    @(negedge sys_clk); chk("clean enable irq", 32'h0, {31'h0, irq});
  endtask : t_reset
  task close_out;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : close_out
  initial begin
    repeat (3) @(posedge sys_clk);
    reset <= 1'b0;
    t_regs;
    t_sources;
    t_reset;
    close_out;
  end
  initial begin
    #100000;
    num_errors++;
    close_out;
  end
endmodule : peripheral_irq_enable_mask_tb
